// File: vfc_pkg.sv
// Package for the video front-end control register bank
`default_nettype none
package vfc_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] TEST_GUARD_OFS   = 8'h54;
  localparam logic [7:0] GAIN_DELAY_OFS   = 8'h60;
  localparam logic [7:0] BURST_DELAY_OFS  = 8'h64;
  localparam logic [7:0] AFE_CTRL_OFS     = 8'h68;
  localparam logic [7:0] EVEN_TIMING_OFS  = 8'h6C;
  localparam logic [7:0] ODD_TIMING_OFS   = 8'hEC;
  localparam logic [7:0] STATUS_OFS       = 8'hF0;

  // ----------------------------------------------------------------
  // Reset and fixed values
  // ----------------------------------------------------------------
  localparam logic [7:0] TEST_GUARD_VAL   = 8'h01;
  localparam logic [7:0] GAIN_DELAY_RST   = 8'h68;
  localparam logic [7:0] BURST_DELAY_RST  = 8'h5D;
  localparam logic [7:0] AFE_CTRL_RST     = 8'h82;
  localparam logic [7:0] TIMING_RST       = 8'h00;

  // ----------------------------------------------------------------
  // Converter interface field positions
  // ----------------------------------------------------------------
  localparam int ADAPT_BIT  = 0;
  localparam int CSLEEP_BIT = 1;
  localparam int YSLEEP_BIT = 2;
  localparam int CKOFF_BIT  = 3;
  localparam int GAINDIS_BIT = 4;
  localparam int SYNCLVL_BIT = 5;

  // ----------------------------------------------------------------
  // Reference voltage step control
  // ----------------------------------------------------------------
  localparam logic [7:0] REF_LEVEL_RST  = 8'h80;
  localparam logic [7:0] REF_LEVEL_MAX  = 8'hFF;

  // Decoded front-end controls
  typedef struct packed {
    logic sync_detect_level;
    logic gain_control_disable;
    logic clock_power_down;
    logic luma_sleep;
    logic chroma_sleep;
    logic adaptive_gain_mode;
  } vfc_ctrl_t;

  // Front-end state machine
  typedef enum logic [1:0] {GAIN_OFF, GAIN_FIXED, GAIN_ADAPT} vfc_gain_state_t;

endpackage : vfc_pkg
`default_nettype wire

// File: vfc_gain_ctrl.sv
// Reference voltage level control for the gain loop
`timescale 1ns/1ps
`default_nettype none
module vfc_gain_ctrl (
  input  wire logic            pclk,
  input  wire logic            presetn,
  input  wire vfc_pkg::vfc_ctrl_t ctrl,
  input  wire logic            luma_overflow,
  input  wire logic            chroma_overflow,
  output logic [7:0]           ref_level,
  output logic                 ref_drive_en,
  output vfc_pkg::vfc_gain_state_t gain_state
);

  // ----------------------------------------------------------------
  // State and level registers
  // ----------------------------------------------------------------
  vfc_pkg::vfc_gain_state_t state_reg, state_next;
  logic [7:0]               level_reg, level_next;
  wire                      ovf = luma_overflow | chroma_overflow;

  // Mode selection from control bits
  always_comb begin
    case (state_reg)
      default: begin
        if (ctrl.gain_control_disable)
          state_next = vfc_pkg::GAIN_OFF;
        else if (ctrl.adaptive_gain_mode)
          state_next = vfc_pkg::GAIN_ADAPT;
        else
          state_next = vfc_pkg::GAIN_FIXED;
      end
    endcase
  end

  // overflow widens range
  // Saturates so a stuck overflow cannot wrap the level back down
  assign level_next = (state_reg == vfc_pkg::GAIN_ADAPT && ovf &&
                       level_reg != vfc_pkg::REF_LEVEL_MAX) ? level_reg + 8'h01 : level_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= vfc_pkg::GAIN_FIXED;
      level_reg <= vfc_pkg::REF_LEVEL_RST;
    end else begin
      state_reg <= state_next;
      level_reg <= level_next;
    end
  end

  // reference driven only while gain active
  assign ref_drive_en = (state_reg != vfc_pkg::GAIN_OFF);
  assign ref_level    = level_reg;
  assign gain_state   = state_reg;

  a_adapt_raise: assert property (@(posedge pclk) disable iff (!presetn)
    (state_reg == vfc_pkg::GAIN_ADAPT && ovf && level_reg != 8'hFF)
    |=> (level_reg == $past(level_reg) + 8'h01))
    else $error("reference level did not rise on overflow");

  a_fixed_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (state_reg != vfc_pkg::GAIN_ADAPT) |=> $stable(level_reg))
    else $error("reference level moved outside adaptive mode");

endmodule : vfc_gain_ctrl
`default_nettype wire

// File: vfc_regs.sv
// APB register bank for the video front-end controls
`timescale 1ns/1ps
`default_nettype none
module vfc_regs (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        luma_overflow,
  input  wire logic        chroma_overflow,
  output logic [7:0]       gain_gate_delay,
  output logic [7:0]       burst_sample_delay,
  output logic             sync_detect_level,
  output logic             luma_sleep,
  output logic             chroma_sleep,
  output logic             decoder_clock_enable,
  output logic [7:0]       reference_voltage_output,
  output logic             reference_voltage_output_en,
  output logic [7:0]       even_field_timing_ctl,
  output logic [7:0]       odd_field_timing_ctl
);

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire wr_en   = psel & penable & pwrite;
  wire lane0   = pstrb[0];
  wire hit_tst = (paddr == vfc_pkg::TEST_GUARD_OFS);
  wire hit_gd  = (paddr == vfc_pkg::GAIN_DELAY_OFS);
  wire hit_bd  = (paddr == vfc_pkg::BURST_DELAY_OFS);
  wire hit_afe = (paddr == vfc_pkg::AFE_CTRL_OFS);
  wire hit_ev  = (paddr == vfc_pkg::EVEN_TIMING_OFS);
  wire hit_od  = (paddr == vfc_pkg::ODD_TIMING_OFS);
  wire hit_st  = (paddr == vfc_pkg::STATUS_OFS);
  wire mapped  = hit_tst | hit_gd | hit_bd | hit_afe | hit_ev | hit_od | hit_st;
  wire wr_byte = wr_en & lane0;

  // Single-cycle access phase; unmapped reads and writes, or status writes, flag an error
  assign pready  = 1'b1;
  assign pslverr = psel & penable & (~mapped | (pwrite & hit_st));

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [7:0] gd_reg, bd_reg, afe_reg, ev_reg, od_reg;
  logic [7:0] gd_next, bd_next, afe_next, ev_next, od_next;

  assign gd_next  = (wr_byte & hit_gd)  ? pwdata[7:0] : gd_reg;
  assign bd_next  = (wr_byte & hit_bd)  ? pwdata[7:0] : bd_reg;
  // converter interface store, all eight bits kept
  assign afe_next = (wr_byte & hit_afe) ? pwdata[7:0] : afe_reg;
  assign ev_next  = (wr_byte & hit_ev)  ? pwdata[7:0] : ev_reg;
  assign od_next  = (wr_byte & hit_od)  ? pwdata[7:0] : od_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gd_reg  <= vfc_pkg::GAIN_DELAY_RST;
      bd_reg  <= vfc_pkg::BURST_DELAY_RST;
      afe_reg <= vfc_pkg::AFE_CTRL_RST;
      ev_reg  <= vfc_pkg::TIMING_RST;
      od_reg  <= vfc_pkg::TIMING_RST;
    end else begin
      gd_reg  <= gd_next;
      bd_reg  <= bd_next;
      afe_reg <= afe_next;
      ev_reg  <= ev_next;
      od_reg  <= od_next;
    end
  end

  // ----------------------------------------------------------------
  // Control decode
  // ----------------------------------------------------------------
  vfc_pkg::vfc_ctrl_t ctrl;
  assign ctrl.sync_detect_level    = afe_reg[vfc_pkg::SYNCLVL_BIT];
  assign ctrl.gain_control_disable = afe_reg[vfc_pkg::GAINDIS_BIT];
  assign ctrl.clock_power_down     = afe_reg[vfc_pkg::CKOFF_BIT];
  assign ctrl.luma_sleep           = afe_reg[vfc_pkg::YSLEEP_BIT];
  assign ctrl.chroma_sleep         = afe_reg[vfc_pkg::CSLEEP_BIT];
  assign ctrl.adaptive_gain_mode   = afe_reg[vfc_pkg::ADAPT_BIT];

  // Sleeping converters cannot report real overflow
  wire luma_ovf_q   = luma_overflow & ~ctrl.luma_sleep;
  wire chroma_ovf_q = chroma_overflow & ~ctrl.chroma_sleep;

  vfc_pkg::vfc_gain_state_t gain_state;

  // Gain loop
  vfc_gain_ctrl u_gain (
    .pclk            (pclk),
    .presetn         (presetn),
    .ctrl            (ctrl),
    .luma_overflow   (luma_ovf_q),
    .chroma_overflow (chroma_ovf_q),
    .ref_level       (reference_voltage_output),
    .ref_drive_en    (reference_voltage_output_en),
    .gain_state      (gain_state)
  );

  // Outputs from flops
  assign gain_gate_delay       = gd_reg;
  assign burst_sample_delay    = bd_reg;
  assign sync_detect_level     = ctrl.sync_detect_level;
  assign luma_sleep            = ctrl.luma_sleep;
  assign chroma_sleep          = ctrl.chroma_sleep;
  // gates only decoder clock, bus logic keeps running
  assign decoder_clock_enable  = ~ctrl.clock_power_down;
  assign even_field_timing_ctl = ev_reg;
  assign odd_field_timing_ctl  = od_reg;

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  wire [7:0] status_byte = {4'h0, reference_voltage_output_en,
                            gain_state == vfc_pkg::GAIN_ADAPT,
                            luma_overflow, chroma_overflow};
  wire [7:0] rd_byte =
    // guard reads constant regardless of writes
    hit_tst ? vfc_pkg::TEST_GUARD_VAL :
    hit_gd  ? gd_reg  :
    hit_bd  ? bd_reg  :
    hit_afe ? afe_reg :
    hit_ev  ? ev_reg  :
    hit_od  ? od_reg  :
    hit_st  ? status_byte : 8'h00;

  // ----------------------------------------------------------------
  // Read data register
  // ----------------------------------------------------------------
  // Captured in the setup phase so the access phase shows a flop output
  logic [31:0] prdata_reg, prdata_next;
  wire         rd_setup  = psel & ~penable & ~pwrite;
  wire         rd_access = psel & penable & ~pwrite;

  // Held through the access phase; upper bits zero, idle bus reads zero
  assign prdata_next = rd_setup  ? {24'h000000, rd_byte} :
                       rd_access ? prdata_reg : 32'h00000000;

  // Read word register, cleared on reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h00000000;
    end else begin
      prdata_reg <= prdata_next;
    end
  end

  assign prdata = prdata_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // guard reads constant
  a_guard_const: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable && !pwrite && hit_tst) |-> (prdata == 32'h00000001))
    else $error("test guard read not constant");

  a_guard_noerr: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable && hit_tst) |-> !pslverr)
    else $error("test guard access refused");

  // Unmapped access refused
  a_unmapped_err: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable && !mapped) |-> pslverr)
    else $error("unmapped access not refused");

  // One byte per word, upper lanes zero
  a_rd_upper: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable && !pwrite) |-> (prdata[31:8] == 24'h000000))
    else $error("upper read lanes not zero");

  // ----------------------------------------------------------------
  // Storage checks
  // ----------------------------------------------------------------
  // gate delay write
  a_gate_write: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_byte && hit_gd) |=> (gd_reg == $past(pwdata[7:0])))
    else $error("gain gate delay write lost");

  a_gate_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !(wr_byte && hit_gd) |=> $stable(gd_reg))
    else $error("gain gate delay changed without write");

  a_gate_read: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable && !pwrite && hit_gd) |-> (prdata[7:0] == gd_reg))
    else $error("gain gate delay read wrong");

  a_burst_write: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_byte && hit_bd) |=> (bd_reg == $past(pwdata[7:0])))
    else $error("burst delay write lost");

  a_burst_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !(wr_byte && hit_bd) |=> $stable(bd_reg))
    else $error("burst delay changed without write");

  a_burst_read: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable && !pwrite && hit_bd) |-> (prdata[7:0] == bd_reg))
    else $error("burst delay read wrong");

  a_afe_write: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_byte && hit_afe) |=> (afe_reg == $past(pwdata[7:0])))
    else $error("converter register write lost");

  a_afe_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !(wr_byte && hit_afe) |=> $stable(afe_reg))
    else $error("converter register changed without write");

  a_afe_read: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable && !pwrite && hit_afe) |-> (prdata[7:0] == afe_reg))
    else $error("converter register read wrong");

  a_even_write: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_byte && hit_ev) |=> (ev_reg == $past(pwdata[7:0])))
    else $error("even timing write lost");

  a_odd_write: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_byte && hit_od) |=> (od_reg == $past(pwdata[7:0])))
    else $error("odd timing write lost");

  a_field_sep: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_byte && hit_ev) |=> $stable(od_reg))
    else $error("odd timing disturbed by even write");

  a_even_sep: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_byte && hit_od) |=> $stable(ev_reg))
    else $error("even timing disturbed by odd write");

  a_even_read: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable && !pwrite && hit_ev) |-> (prdata[7:0] == ev_reg))
    else $error("even timing read wrong");

  a_odd_read: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable && !pwrite && hit_od) |-> (prdata[7:0] == od_reg))
    else $error("odd timing read wrong");

  // ----------------------------------------------------------------
  // Control checks
  // ----------------------------------------------------------------
  // sync threshold follows write
  a_sync_level: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_byte && hit_afe) |=> (sync_detect_level == $past(pwdata[vfc_pkg::SYNCLVL_BIT])))
    else $error("sync threshold mismatch");

  a_ref_release: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_byte && hit_afe && pwdata[4]) |=> ##1 !reference_voltage_output_en)
    else $error("reference still driven with gain off");

  a_ref_drive: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_byte && hit_afe && !pwdata[4]) |=> ##1 reference_voltage_output_en)
    else $error("reference not driven with gain on");

  // drive trails the bit by one edge
  a_ref_follow: assert property (@(posedge pclk) disable iff (!presetn)
    reference_voltage_output_en == !$past(afe_reg[vfc_pkg::GAINDIS_BIT]))
    else $error("reference drive out of step with gain bit");

  a_clk_down: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_byte && hit_afe) |=> (decoder_clock_enable == !$past(pwdata[3])))
    else $error("decoder clock enable wrong");

  a_clk_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !(wr_byte && hit_afe) |=> $stable(decoder_clock_enable))
    else $error("decoder clock enable changed without write");

  a_clk_bus: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable && !pwrite && hit_afe && !decoder_clock_enable) |->
    prdata[vfc_pkg::CKOFF_BIT])
    else $error("register read lost during power-down");

  a_sleep_bits: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_byte && hit_afe) |=> (luma_sleep == $past(pwdata[2]) &&
                              chroma_sleep == $past(pwdata[1])))
    else $error("converter sleep bits wrong");

  a_sleep_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !(wr_byte && hit_afe) |=> ($stable(luma_sleep) && $stable(chroma_sleep)))
    else $error("converter sleep changed without write");

  a_level_mono: assert property (@(posedge pclk) disable iff (!presetn)
    reference_voltage_output >= $past(reference_voltage_output))
    else $error("reference level fell");

  a_sleep_mask: assert property (@(posedge pclk) disable iff (!presetn)
    (luma_sleep && chroma_sleep) |=> $stable(reference_voltage_output))
    else $error("reference rose with both converters asleep");

endmodule : vfc_regs
`default_nettype wire

// File: vfc_tb.sv
// Self-checking bench for the video front-end control register bank
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0]  pstrb = 4'h0;
  logic        luma_overflow = 1'b0;
  logic        chroma_overflow = 1'b0;
  logic [31:0] prdata;
  logic        pready, pslverr, sync_detect_level, luma_sleep, chroma_sleep;
  logic        decoder_clock_enable, reference_voltage_output_en;
  logic [7:0]  gain_gate_delay, burst_sample_delay, reference_voltage_output;
  logic [7:0]  even_field_timing_ctl, odd_field_timing_ctl;
  int          err_total = 0;
  int          comparisons = 0;
  logic [31:0] rd;
  logic        er;
  logic [7:0]  v, a;
  logic [7:0]  addr_tab [5] = '{vfc_pkg::GAIN_DELAY_OFS, vfc_pkg::BURST_DELAY_OFS,
    vfc_pkg::EVEN_TIMING_OFS, vfc_pkg::ODD_TIMING_OFS, vfc_pkg::TEST_GUARD_OFS};

  vfc_regs u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .luma_overflow(luma_overflow),
    .chroma_overflow(chroma_overflow), .gain_gate_delay(gain_gate_delay),
    .burst_sample_delay(burst_sample_delay), .sync_detect_level(sync_detect_level),
    .luma_sleep(luma_sleep), .chroma_sleep(chroma_sleep),
    .decoder_clock_enable(decoder_clock_enable),
    .reference_voltage_output(reference_voltage_output),
    .reference_voltage_output_en(reference_voltage_output_en),
    .even_field_timing_ctl(even_field_timing_ctl), .odd_field_timing_ctl(odd_field_timing_ctl));

  // 250 MHz register clock
  always #2 pclk = ~pclk;

  // ----------------------------------------------------------------
  // Verdict, compare and bus tasks
  // ----------------------------------------------------------------
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : give_verdict

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // One full APB transfer; entered just after a rising edge, leaves one edge after release
  task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] d);
    int n;
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= ad; pwdata <= d; pstrb <= 4'hF;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      err_total++;
      give_verdict();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  // Read value a register should give after writing d
  function automatic logic [31:0] exp_rd(input logic [7:0] ad, input logic [7:0] d);
    return (ad == vfc_pkg::TEST_GUARD_OFS) ? 32'h01 : {24'h0, d};
  endfunction : exp_rd

  // Port that mirrors each plain register
  function automatic logic [7:0] port_of(input logic [7:0] ad);
    case (ad)
      vfc_pkg::GAIN_DELAY_OFS:  return gain_gate_delay;
      vfc_pkg::BURST_DELAY_OFS: return burst_sample_delay;
      vfc_pkg::EVEN_TIMING_OFS: return even_field_timing_ctl;
      default:                  return odd_field_timing_ctl;
    endcase
  endfunction : port_of

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(58776));
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // Reset values of every writable register, of chroma sleep and of the reference outputs
    apb(0, vfc_pkg::GAIN_DELAY_OFS, 0);  chk("gain delay rst", 32'h68, rd);
    apb(0, vfc_pkg::BURST_DELAY_OFS, 0); chk("burst delay rst", 32'h5D, rd);
    apb(0, vfc_pkg::AFE_CTRL_OFS, 0);    chk("ctrl rst", 32'h82, rd);
    apb(0, vfc_pkg::EVEN_TIMING_OFS, 0); chk("even rst", 32'h00, rd);
    apb(0, vfc_pkg::ODD_TIMING_OFS, 0);  chk("odd rst", 32'h00, rd);
    apb(0, vfc_pkg::TEST_GUARD_OFS, 0);  chk("test guard rst", 32'h01, rd);
    chk("chroma sleep rst", 32'h1, chroma_sleep);
    chk("ref en rst", 32'h1, reference_voltage_output_en);
    chk("ref level rst", 32'h80, reference_voltage_output);
    $display("test reset done");
    // Non-adaptive mode ignores converter overflow
    luma_overflow <= 1'b1; chroma_overflow <= 1'b1;
    repeat (10) @(posedge pclk);
    luma_overflow <= 1'b0; chroma_overflow <= 1'b0;
    chk("ref level fixed", 32'h80, reference_voltage_output);
    $display("test non-adaptive done");
    // Random writes with readback; the guard only ever sees 0x01
    // guard written with 0x01 alone
    apb(1, vfc_pkg::TEST_GUARD_OFS, 32'h01);
    for (int i = 0; i < 14; i++) begin
      a = addr_tab[$urandom_range(4)];
      v = (a == vfc_pkg::TEST_GUARD_OFS) ? 8'h01 : 8'($urandom);
      apb(1, a, {24'h0, v});
      apb(0, a, 0);
      chk("readback", exp_rd(a, v), rd);
      if (a != vfc_pkg::TEST_GUARD_OFS) chk("reg port", v, port_of(a));
    end
    $display("test random rw done");
    // Each control bit alone, top pair kept at pattern 10
    // bits 7:6 always written as 10
    // bit 5 set only in its own step
    for (int i = 0; i < 6; i++) begin
      v = 8'h80 | (8'h01 << i);
      apb(1, vfc_pkg::AFE_CTRL_OFS, {24'h0, v});
      @(posedge pclk);
      apb(0, vfc_pkg::AFE_CTRL_OFS, 0); chk("ctrl readback", v, rd);
      chk("sync level", v[5], sync_detect_level);
      chk("gain drive", !v[4], reference_voltage_output_en);
      chk("clock enable", !v[3], decoder_clock_enable);
      chk("luma sleep", v[2], luma_sleep);
      chk("chroma sleep", v[1], chroma_sleep);
    end
    $display("test ctrl bits done");
    // Adaptive gain climbs on overflow, saturates and never falls back
    apb(1, vfc_pkg::AFE_CTRL_OFS, 32'h81);
    luma_overflow <= 1'b1;
    repeat (20) @(posedge pclk);
    chk("ref rising", 32'h1, reference_voltage_output > 8'h80);
    apb(0, vfc_pkg::STATUS_OFS, 0); chk("status adaptive", 32'h0E, rd);
    repeat (280) @(posedge pclk);
    chk("ref saturate", 32'hFF, reference_voltage_output);
    luma_overflow <= 1'b0;
    apb(1, vfc_pkg::AFE_CTRL_OFS, 32'h80);
    repeat (4) @(posedge pclk);
    chk("ref hold", 32'hFF, reference_voltage_output);
    $display("test adaptive done");
    // Unmapped place and the read-only status word refuse
    apb(1, 8'h58, 32'hA5); chk("unmapped wr err", 32'h1, er);
    apb(0, 8'h58, 0);      chk("unmapped rd err", 32'h1, er);
    chk("unmapped rd data", 32'h0, rd);
    apb(1, vfc_pkg::STATUS_OFS, 32'h0F); chk("status wr err", 32'h1, er);
    apb(0, vfc_pkg::TEST_GUARD_OFS, 0);  chk("guard ok", 32'h0, er);
    $display("test refusals done");
    give_verdict();
  end
endmodule : testbench
`default_nettype wire
